// ==== src/pdl_cfg.svh ====
`ifndef PDL_CFG_SVH
`define PDL_CFG_SVH
// Reset and idle levels of the outputs
`define PDL_UP_IDLE     1'h0
`define PDL_DN_IDLE     1'h0
`define PDL_LOCK_IDLE   1'h1
`define PDL_OE_OFF      1'h1
`define PDL_OE_ON       1'h0
`define PDL_MON_RST     1'h0
// Resting levels of the comparator outputs
`define PDL_VSIDE_REST  1'h1
`define PDL_RSIDE_REST  1'h0
// Synchroniser stage and accepted level reset values
`define PDL_SYNC_RST    3'h0
`define PDL_LVL_RST     1'h0
`endif

// ==== src/pdl_pkg.sv ====
package pdl_pkg;
   // Phase detector state: which side has seen an unanswered edge
   typedef enum logic [1:0] {
      PDL_IDLE,
      PDL_UP,
      PDL_DN
   } pdl_state_t;
endpackage : pdl_pkg

// ==== src/pdl_sync.sv ====
`timescale 1ns/10ps
`include "pdl_cfg.svh"
module pdl_sync (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout,
   output logic      rise
);
   logic [2:0] stage_reg;
   logic       level_reg;

   // Three stage synchroniser
   always_ff @(posedge mclk) begin
      if (rst) begin
         stage_reg <= `PDL_SYNC_RST;
      end else begin
         stage_reg <= {stage_reg[1:0], din};
      end
   end

   // Accept a change once second and third stages agree
   always_ff @(posedge mclk) begin
      if (rst) begin
         level_reg <= `PDL_LVL_RST;
      end else if (stage_reg[1] == stage_reg[2]) begin
         level_reg <= stage_reg[2];
      end
   end

   assign dout = level_reg;
   assign rise = (stage_reg[1] == stage_reg[2]) && stage_reg[2] && !level_reg;
endmodule : pdl_sync

// ==== src/pdl_top.sv ====
`timescale 1ns/10ps
`include "pdl_cfg.svh"
// Functional notes
// - In lock, VCO-side high, reference-side spikes high on coincident edges
// - Polarity high: monitor shows divided reference
// - Polarity low: monitor shows divided VCO
// - Pump drive sense follows frequency and polarity
// - Equal signals: pump output high impedance
// - Lock indicator rests high, pulses low
// - Lock indicator is NOR of up/down
// - Load enable high: bypass pump tracks main
// - Load enable low: bypass pump high impedance
// - Lead/lag judged from leading edges
// - Reference lag pulses reference-side output; polarity reverses
module pdl_top
   import pdl_pkg::*;
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic divided_reference,
   input  wire logic divided_vco,
   input  wire logic polarity_select,
   input  wire logic load_enable_pin,
   output logic      vco_side_out,
   output logic      ref_side_out,
   output logic      pump_out,
   output logic      pump_oe_n,
   output logic      bypass_pump_out,
   output logic      bypass_pump_oe_n,
   output logic      lock_indicator,
   output logic      test_monitor
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   logic ref_lvl, ref_rise, vco_lvl, vco_rise, pol_lvl, le_lvl;

   pdl_sync u_ref (
      .mclk (mclk),
      .rst  (rst),
      .din  (divided_reference),
      .dout (ref_lvl),
      .rise (ref_rise)
   );
   pdl_sync u_vco (
      .mclk (mclk),
      .rst  (rst),
      .din  (divided_vco),
      .dout (vco_lvl),
      .rise (vco_rise)
   );
   pdl_sync u_pol (
      .mclk (mclk),
      .rst  (rst),
      .din  (polarity_select),
      .dout (pol_lvl),
      .rise ()
   );
   pdl_sync u_le (
      .mclk (mclk),
      .rst  (rst),
      .din  (load_enable_pin),
      .dout (le_lvl),
      .rise ()
   );

   // ------------------------------------------------------------
   // Phase frequency detector
   // ------------------------------------------------------------
   pdl_state_t state_reg;
   logic       up_next;
   logic       dn_next;
   logic       spike_next;

   // Edge race: reference edge first raises up, VCO edge first raises down
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= PDL_IDLE;
      end else begin
         unique case (state_reg)
            PDL_IDLE: begin
               if (ref_rise && !vco_rise) begin
                  state_reg <= PDL_UP;
               end else if (vco_rise && !ref_rise) begin
                  state_reg <= PDL_DN;
               end
            end
            PDL_UP: begin
               if (vco_rise) begin
                  state_reg <= ref_rise ? PDL_UP : PDL_IDLE;
               end
            end
            PDL_DN: begin
               if (ref_rise) begin
                  state_reg <= vco_rise ? PDL_DN : PDL_IDLE;
               end
            end
         endcase
      end
   end

   // Up means VCO too slow, down means VCO too fast
   always_comb begin
      up_next    = (state_reg == PDL_UP);
      dn_next    = (state_reg == PDL_DN);
      spike_next = (state_reg == PDL_IDLE) && ref_rise && vco_rise;
   end

   // ------------------------------------------------------------
   // Comparator outputs
   // ------------------------------------------------------------
   logic vside_next;
   logic rside_next;

   // Polarity picks which pending side pulses each output
   always_comb begin
      if (pol_lvl) begin
         vside_next = !up_next;
         rside_next = dn_next || spike_next;
      end else begin
         vside_next = !dn_next;
         rside_next = up_next || spike_next;
      end
   end

   // VCO-side output register, rests high
   always_ff @(posedge mclk) begin
      if (rst) begin
         vco_side_out <= `PDL_VSIDE_REST;
      end else begin
         vco_side_out <= vside_next;
      end
   end

   // Reference-side output register, rests low apart from spikes
   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_side_out <= `PDL_RSIDE_REST;
      end else begin
         ref_side_out <= rside_next;
      end
   end

   // ------------------------------------------------------------
   // Charge pumps
   // ------------------------------------------------------------
   logic pump_drv;
   logic pump_act;

   always_comb begin
      pump_act = up_next || dn_next;
      pump_drv = pol_lvl ? up_next : dn_next;
   end

   logic pump_oe_next;
   logic byp_oe_next;

   // Output enables: balanced detector leaves both pumps floating;
   // the bypass pump is also released while load enable is low
   always_comb begin
      pump_oe_next = pump_act ? `PDL_OE_ON : `PDL_OE_OFF;
      byp_oe_next  = (pump_act && le_lvl) ? `PDL_OE_ON
                                          : `PDL_OE_OFF;
   end

   // Main pump drive level
   always_ff @(posedge mclk) begin
      if (rst) begin
         pump_out <= `PDL_UP_IDLE;
      end else begin
         pump_out <= pump_drv;
      end
   end

   // Main pump enable, never gated by load enable
   always_ff @(posedge mclk) begin
      if (rst) begin
         pump_oe_n <= `PDL_OE_OFF;
      end else begin
         pump_oe_n <= pump_oe_next;
      end
   end

   // Bypass pump drive level tracks the main pump
   always_ff @(posedge mclk) begin
      if (rst) begin
         bypass_pump_out <= `PDL_DN_IDLE;
      end else begin
         bypass_pump_out <= pump_drv;
      end
   end

   // Bypass pump enable follows main pump only with load enable high
   always_ff @(posedge mclk) begin
      if (rst) begin
         bypass_pump_oe_n <= `PDL_OE_OFF;
      end else begin
         bypass_pump_oe_n <= byp_oe_next;
      end
   end

   // ------------------------------------------------------------
   // Lock indicator and test monitor
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         lock_indicator <= `PDL_LOCK_IDLE;
      end else begin
         lock_indicator <= !(up_next || dn_next);
      end
   end

   // Monitor picks divider output by polarity
   always_ff @(posedge mclk) begin
      if (rst) begin
         test_monitor <= `PDL_MON_RST;
      end else begin
         test_monitor <= pol_lvl ? ref_lvl : vco_lvl;
      end
   end
endmodule : pdl_top

// ==== tb/pdl_src.sv ====
`timescale 1ns/10ps
// ------
// Divider source
// ------
module pdl_src (
   input  wire logic mclk,
   input  wire logic rst,
   input  var  int   hr,
   input  var  int   hv,
   output logic      ref_o,
   output logic      vco_o
);
   int cr;
   int cv;
   // Square waves, held low in reset
   always_ff @(posedge mclk) begin
      cr <= (rst || cr >= hr - 1) ? 0 : cr + 1;
      ref_o <= !rst && (ref_o ^ (cr >= hr - 1));
      cv <= (rst || cv >= hv - 1) ? 0 : cv + 1;
      vco_o <= !rst && (vco_o ^ (cv >= hv - 1));
   end
endmodule : pdl_src

// ==== tb/pdl_top_assertions.sv ====
`timescale 1ns/10ps
// ------
// Checks
// ------
module pdl_top_check (
   input wire logic mclk,
   input wire logic rst,
   input wire logic divided_reference,
   input wire logic divided_vco,
   input wire logic polarity_select,
   input wire logic load_enable_pin,
   input wire logic vco_side_out,
   input wire logic ref_side_out,
   input wire logic pump_out,
   input wire logic pump_oe_n,
   input wire logic bypass_pump_out,
   input wire logic bypass_pump_oe_n,
   input wire logic lock_indicator,
   input wire logic test_monitor
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_lock_nor: assert property (lock_indicator == pump_oe_n)
      else $error("lock");
   a_rest_lvl: assert property (pump_oe_n |-> vco_side_out)
      else $error("rest");
   a_drive_sense: assert property (!pump_oe_n |->
      pump_out != ref_side_out && vco_side_out == ref_side_out)
      else $error("sense");
   a_byp_track: assert property (load_enable_pin[*6] |->
      bypass_pump_oe_n == pump_oe_n && (pump_oe_n || bypass_pump_out == pump_out))
      else $error("track");
   a_byp_off: assert property ((!load_enable_pin)[*6] |-> bypass_pump_oe_n)
      else $error("bypass");
   a_mon_ref: assert property (polarity_select[*8] ##0 $rose(test_monitor)
      |-> divided_reference) else $error("mon ref");
   a_mon_vco: assert property ((!polarity_select)[*8] ##0 $rose(test_monitor)
      |-> divided_vco) else $error("mon vco");
   a_pulse_len: assert property ($fell(lock_indicator) |->
      ##[1:300] lock_indicator) else $error("pulse");
   c_up: cover property ($fell(lock_indicator) && pump_out);
   c_dn: cover property ($fell(lock_indicator) && !pump_out);
   c_spike: cover property (ref_side_out && pump_oe_n);
endmodule : pdl_top_check
bind pdl_top pdl_top_check chk_u (.*);

// ==== tb/pdl_top_test.sv ====
`timescale 1ns/10ps
// ------
// Bench
// ------
module pdl_top_test;
   logic mclk, rst, polarity_select, load_enable_pin;
   logic divided_reference, divided_vco, vco_side_out, ref_side_out;
   logic pump_out, pump_oe_n, bypass_pump_out, bypass_pump_oe_n;
   logic lock_indicator, test_monitor;
   int   hr, hv, n_mismatch, comparisons;
   pdl_top dut_u (.*);
   pdl_src src_u (.mclk, .rst, .hr, .hv, .ref_o(divided_reference),
                  .vco_o(divided_vco));
   initial begin
      mclk = 0;
      forever #4 mclk = ~mclk;
   end
   task chk(input string n, input logic e, input logic s);
      comparisons++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error %s expected %0b seen %0b", n, e, s);
      end
   endtask : chk
   task conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   task restart;
      rst <= 1'h1;
      repeat (12) @(posedge mclk);
      rst <= 1'h0;
   endtask : restart
   // Matched inputs: outputs at rest
   task t_lock;
      int bad;
      bad = 0;
      hv <= hr;
      restart;
      repeat (300) begin
         @(posedge mclk);
         if ({lock_indicator, pump_oe_n, vco_side_out} !== 3'h7) bad++;
      end
      chk("rest", 1'h0, bad != 0);
   endtask : t_lock
   // Frequency offset: pump sense, bypass, monitor
   task t_pump(input int v, input logic p, input logic l);
      int bad, lows, mr, sr;
      logic pm, ps, want;
      bad = 0;
      lows = 0;
      mr = 0;
      sr = 0;
      pm = 0;
      ps = 0;
      want = ((v > hr) == p);
      polarity_select <= p;
      load_enable_pin <= l;
      hv <= v;
      restart;
      repeat (400) begin
         @(posedge mclk);
         if (lock_indicator === 1'h0) lows++;
         if (!pump_oe_n && pump_out !== want) bad++;
         if (!pump_oe_n && ref_side_out !== !want) bad++;
         if (!pump_oe_n && vco_side_out !== !want) bad++;
         if (bypass_pump_oe_n !== (l ? pump_oe_n : 1'h1)) bad++;
         if (!bypass_pump_oe_n && bypass_pump_out !== want) bad++;
         if (test_monitor && !pm) mr++;
         if ((p ? divided_reference : divided_vco) && !ps) sr++;
         pm = test_monitor;
         ps = p ? divided_reference : divided_vco;
      end
      chk("pump", 1'h0, bad != 0);
      chk("lock", 1'h1, lows > 0);
      chk("monitor", 1'h1, mr >= sr - 1 && mr <= sr + 1);
   endtask : t_pump
   initial begin
      rst = 1; polarity_select = 1; load_enable_pin = 1;
      hr = 20; hv = 20; n_mismatch = 0; comparisons = 0;
      t_lock;
      t_pump(30, 1'h1, 1'h1);
      t_pump(30, 1'h0, 1'h1);
      t_pump(13, 1'h1, 1'h1);
      t_pump(13, 1'h0, 1'h0);
      conclude;
   end
   // Watchdog
   initial begin
      repeat (6000) @(posedge mclk);
      n_mismatch++;
      conclude;
   end
endmodule : pdl_top_test
